// [logic/pio_consts.vh]
// Purpose: constants for the parallel line controller
// Assumes: included by the line controller, its monitor and its bench
// Notes:   byte offsets of the 32-bit register words
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

`define PIO_OFS_OWN_EN      12'h000
`define PIO_OFS_OWN_DIS     12'h004
`define PIO_OFS_OWN_STAT    12'h008
`define PIO_OFS_DRV_EN      12'h010
`define PIO_OFS_DRV_DIS     12'h014
`define PIO_OFS_DRV_STAT    12'h018
`define PIO_OFS_LVL_SET     12'h030
`define PIO_OFS_LVL_CLR     12'h034
`define PIO_OFS_LVL_STAT    12'h038
`define PIO_OFS_PIN_STAT    12'h03c
`define PIO_OFS_IRQ_EN      12'h040
`define PIO_OFS_IRQ_DIS     12'h044
`define PIO_OFS_IRQ_MASK    12'h048
`define PIO_OFS_IRQ_STAT    12'h04c
`define PIO_OFS_PU_DIS      12'h060
`define PIO_OFS_PU_EN       12'h064
`define PIO_OFS_PU_STAT     12'h068
`define PIO_OFS_A_SEL       12'h070
`define PIO_OFS_B_SEL       12'h074
`define PIO_OFS_AB_STAT     12'h078
`define PIO_OFS_SWM_SET     12'h0a0
`define PIO_OFS_SWM_CLR     12'h0a4
`define PIO_OFS_SWM_STAT    12'h0a8
`define PIO_OFS_CLK_CTRL    12'h0f0

`define PIO_RST_PULLUP      32'h00000000
`define PIO_RST_AB          32'h00000000
`define PIO_RST_SWM         32'h00000000
`define PIO_RST_DRV         32'h00000000
`define PIO_RST_LVL         32'h00000000
`define PIO_RST_IRQ         32'h00000000
`define PIO_RST_CLK         1'b0

`define PIO_RESP_OKAY       2'b00
`define PIO_RESP_SLVERR     2'b10

`endif

// [logic/pio_setclr.v]
// Purpose: one set/clear/status register word
// Assumes: set and clear strobes last one clock
// Notes:   unimplemented lines stay at zero, unmuxed lines forced
`timescale 1ns/10ps
module pio_setclr #(
	parameter WIDTH     = 32,
	parameter RST_VALUE = 32'h00000000,
	parameter FORCE_ONE = 32'h00000000,
	parameter IMPL_MASK = 32'hffffffff
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             set_stb,
	input  wire             clr_stb,
	input  wire             load_stb,
	input  wire [WIDTH-1:0] load_mask,
	input  wire [WIDTH-1:0] wdata,
	output reg  [WIDTH-1:0] status
);
	// ----------------------------------------
	// per-bit update
	// ----------------------------------------
	reg [WIDTH-1:0] status_next;

	always @* begin
		status_next = status;
		if (set_stb) begin
			status_next = status | wdata;
		end else if (clr_stb) begin
			status_next = status & ~wdata;
		end else if (load_stb) begin
			status_next = (status & ~load_mask) | (wdata & load_mask);
		end
		status_next = (status_next | FORCE_ONE[WIDTH-1:0]) & IMPL_MASK[WIDTH-1:0];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			status <= (RST_VALUE[WIDTH-1:0] | FORCE_ONE[WIDTH-1:0]) & IMPL_MASK[WIDTH-1:0];
		end else begin
			status <= status_next;
		end
	end
endmodule

// [logic/pio_pinmux.v]
// Purpose: per-line output multiplexer between controller and peripherals
// Assumes: enables are active low at the pin
// Notes:   combinational; the top registers the results
`timescale 1ns/10ps
module pio_pinmux #(
	parameter WIDTH = 32
) (
	input  wire [WIDTH-1:0] own,
	input  wire [WIDTH-1:0] ab_sel,
	input  wire [WIDTH-1:0] drv,
	input  wire [WIDTH-1:0] lvl,
	input  wire [WIDTH-1:0] pa_out,
	input  wire [WIDTH-1:0] pa_oe,
	input  wire [WIDTH-1:0] pb_out,
	input  wire [WIDTH-1:0] pb_oe,
	output wire [WIDTH-1:0] mux_out,
	output wire [WIDTH-1:0] mux_oe_n
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_line
			wire p_out;
			wire p_oe;
			assign p_out       = ab_sel[i] ? pb_out[i] : pa_out[i];
			assign p_oe        = ab_sel[i] ? pb_oe[i] : pa_oe[i];
			assign mux_out[i]  = own[i] ? lvl[i] : p_out;
			assign mux_oe_n[i] = own[i] ? ~drv[i] : ~p_oe;
		end
	endgenerate
endmodule

// [logic/pio_line_ctrl.v]
// Purpose: parallel line controller with AXI4-Lite register access
// Assumes: single clock aclk, synchronous active-low reset, pins synchronous
// Notes:   gated clock modelled as an enable bit for sampling and change detection
//
// Overview of operation
// - up to 32 lines, line n on bit n of each register
// - pull-up enable clears status bit, disable sets it; 1 means off
// - all pull-ups on after reset, status zero
// - line enable sets ownership, disable clears; 0 hands pin to peripheral
// - unmuxed lines ignore ownership writes and read ownership 1
// - ownership reset value per line is a product parameter
// - A select clears, B select sets the select status bit
// - select steers outputs only; both peripherals always see the pin
// - select status resets to zero, peripheral A
// - select writes act regardless of ownership; software writes both
// - peripheral-owned pin takes drive and level from selected peripheral
// - drive enable sets, drive disable clears; 1 means controller drives
// - level set and clear writes set or clear the driven level
// - drive and level writes act whoever owns the pin
// - direct level write changes only bits with mask set
// - mask set and clear writes set or clear mask bits
// - write mask resets to zero
// - register writes never depend on the gated clock
// - sampling, change detection and interrupt only with clock enabled
// - one interrupt output towards the interrupt controller
// - pin level register holds last sample while clock stopped
// - change sets status, output ors masked bits, read clears all but a change in the read cycle
`timescale 1ns/10ps
`include "pio_consts.vh"
module pio_line_ctrl #(
	parameter WIDTH     = 32,
	parameter IMPL_MASK = 32'hffffffff,
	parameter MUX_MASK  = 32'hffffffff,
	parameter OWN_RST   = 32'hffffffff
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [11:0]      s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [11:0]      s_axi_araddr,
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_out,
	output reg  [WIDTH-1:0] pin_oe_n,
	output reg  [WIDTH-1:0] pullup_on,
	input  wire [WIDTH-1:0] periph_a_out,
	input  wire [WIDTH-1:0] periph_a_oe,
	input  wire [WIDTH-1:0] periph_b_out,
	input  wire [WIDTH-1:0] periph_b_oe,
	output reg  [WIDTH-1:0] periph_a_in,
	output reg  [WIDTH-1:0] periph_b_in,
	output reg              change_irq
);
	// ----------------------------------------
	// write channel capture
	// ----------------------------------------
	localparam [WIDTH-1:0] IMPL = IMPL_MASK[WIDTH-1:0];

	reg  [11:0]      waddr_reg;
	reg  [31:0]      wdata_reg;
	reg              have_aw_reg;
	reg              have_w_reg;
	reg              wr_go;
	reg              wr_err;
	wire [WIDTH-1:0] wval;

	assign wval = wdata_reg[WIDTH-1:0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			waddr_reg     <= 12'h000;
			wdata_reg     <= 32'h00000000;
			have_aw_reg   <= 1'b0;
			have_w_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PIO_RESP_OKAY;
		end else begin
			s_axi_awready <= ~have_aw_reg & ~s_axi_awready & ~s_axi_bvalid & ~wr_go;
			s_axi_wready  <= ~have_w_reg & ~s_axi_wready & ~s_axi_bvalid & ~wr_go;
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_reg   <= s_axi_awaddr;
				have_aw_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				// partial strobes still update the whole word
				wdata_reg  <= s_axi_wdata;
				have_w_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				have_aw_reg  <= 1'b0;
				have_w_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `PIO_RESP_SLVERR : `PIO_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	function is_wr;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			is_wr = (addr[11:2] == ofs[11:2]);
		end
	endfunction

	reg w_own_en, w_own_dis, w_drv_en, w_drv_dis, w_lvl_set, w_lvl_clr, w_lvl_ld;
	reg w_irq_en, w_irq_dis, w_pu_en, w_pu_dis, w_a_sel, w_b_sel;
	reg w_swm_set, w_swm_clr, w_clk;

	always @* begin
		wr_go     = have_aw_reg & have_w_reg & ~s_axi_bvalid;
		w_own_en  = 1'b0;
		w_own_dis = 1'b0;
		w_drv_en  = 1'b0;
		w_drv_dis = 1'b0;
		w_lvl_set = 1'b0;
		w_lvl_clr = 1'b0;
		w_lvl_ld  = 1'b0;
		w_irq_en  = 1'b0;
		w_irq_dis = 1'b0;
		w_pu_en   = 1'b0;
		w_pu_dis  = 1'b0;
		w_a_sel   = 1'b0;
		w_b_sel   = 1'b0;
		w_swm_set = 1'b0;
		w_swm_clr = 1'b0;
		w_clk     = 1'b0;
		wr_err    = 1'b0;
		if (is_wr(waddr_reg, `PIO_OFS_OWN_EN)) begin
			w_own_en = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_OWN_DIS)) begin
			w_own_dis = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_DRV_EN)) begin
			w_drv_en = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_DRV_DIS)) begin
			w_drv_dis = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_LVL_SET)) begin
			w_lvl_set = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_LVL_CLR)) begin
			w_lvl_clr = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_LVL_STAT)) begin
			w_lvl_ld = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_IRQ_EN)) begin
			w_irq_en = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_IRQ_DIS)) begin
			w_irq_dis = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_PU_EN)) begin
			w_pu_en = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_PU_DIS)) begin
			w_pu_dis = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_A_SEL)) begin
			w_a_sel = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_B_SEL)) begin
			w_b_sel = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_SWM_SET)) begin
			w_swm_set = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_SWM_CLR)) begin
			w_swm_clr = wr_go;
		end else if (is_wr(waddr_reg, `PIO_OFS_CLK_CTRL)) begin
			w_clk = wr_go;
		end else begin
			wr_err = 1'b1;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	wire [WIDTH-1:0] pullup_status;
	wire [WIDTH-1:0] line_own_status;
	wire [WIDTH-1:0] periph_ab_status;
	wire [WIDTH-1:0] drive_status;
	wire [WIDTH-1:0] out_level_status;
	wire [WIDTH-1:0] sync_write_mask_status;
	wire [WIDTH-1:0] change_irq_mask;
	wire [WIDTH-1:0] no_mask;

	assign no_mask = {WIDTH{1'b0}};

	// all of these update on aclk, not on the gated sampling enable
	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(`PIO_RST_PULLUP), .IMPL_MASK(IMPL_MASK)) u_pu (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_pu_dis), .clr_stb(w_pu_en),
		.load_stb(1'b0), .load_mask(no_mask), .wdata(wval), .status(pullup_status));

	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(OWN_RST), .FORCE_ONE(~MUX_MASK),
		.IMPL_MASK(IMPL_MASK)) u_own (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_own_en), .clr_stb(w_own_dis),
		.load_stb(1'b0), .load_mask(no_mask), .wdata(wval), .status(line_own_status));

	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(`PIO_RST_AB), .IMPL_MASK(IMPL_MASK)) u_ab (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_b_sel), .clr_stb(w_a_sel),
		.load_stb(1'b0), .load_mask(no_mask), .wdata(wval), .status(periph_ab_status));

	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(`PIO_RST_DRV), .IMPL_MASK(IMPL_MASK)) u_drv (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_drv_en), .clr_stb(w_drv_dis),
		.load_stb(1'b0), .load_mask(no_mask), .wdata(wval), .status(drive_status));

	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(`PIO_RST_LVL), .IMPL_MASK(IMPL_MASK)) u_lvl (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_lvl_set), .clr_stb(w_lvl_clr),
		.load_stb(w_lvl_ld), .load_mask(sync_write_mask_status), .wdata(wval),
		.status(out_level_status));

	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(`PIO_RST_SWM), .IMPL_MASK(IMPL_MASK)) u_swm (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_swm_set), .clr_stb(w_swm_clr),
		.load_stb(1'b0), .load_mask(no_mask), .wdata(wval),
		.status(sync_write_mask_status));

	pio_setclr #(.WIDTH(WIDTH), .RST_VALUE(`PIO_RST_IRQ), .IMPL_MASK(IMPL_MASK)) u_imr (
		.aclk(aclk), .aresetn(aresetn), .set_stb(w_irq_en), .clr_stb(w_irq_dis),
		.load_stb(1'b0), .load_mask(no_mask), .wdata(wval), .status(change_irq_mask));

	// ----------------------------------------
	// gated sampling clock, pin sampling, change detect
	// ----------------------------------------
	reg              clk_on_reg;
	reg [WIDTH-1:0]  pin_level_status;
	reg [WIDTH-1:0]  change_irq_status;
	reg              rd_isr;
	wire [WIDTH-1:0] change;

	assign change = (pin_in ^ pin_level_status) & IMPL;

	always @(posedge aclk) begin
		if (!aresetn) begin
			clk_on_reg        <= `PIO_RST_CLK;
			pin_level_status  <= {WIDTH{1'b0}};
			change_irq_status <= {WIDTH{1'b0}};
			change_irq        <= 1'b0;
		end else begin
			if (w_clk) begin
				clk_on_reg <= wdata_reg[0];
			end
			if (clk_on_reg) begin
				pin_level_status <= pin_in & IMPL;
			end
			// a change in the read cycle survives the clear
			if (clk_on_reg) begin
				change_irq_status <= (rd_isr ? {WIDTH{1'b0}} : change_irq_status) | change;
			end else if (rd_isr) begin
				change_irq_status <= {WIDTH{1'b0}};
			end
			change_irq <= clk_on_reg & |(change_irq_status & change_irq_mask);
		end
	end

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	wire [WIDTH-1:0] mux_out;
	wire [WIDTH-1:0] mux_oe_n;

	pio_pinmux #(.WIDTH(WIDTH)) u_mux (
		.own(line_own_status), .ab_sel(periph_ab_status), .drv(drive_status),
		.lvl(out_level_status), .pa_out(periph_a_out), .pa_oe(periph_a_oe),
		.pb_out(periph_b_out), .pb_oe(periph_b_oe), .mux_out(mux_out),
		.mux_oe_n(mux_oe_n));

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out     <= {WIDTH{1'b0}};
			pin_oe_n    <= {WIDTH{1'b1}};
			pullup_on   <= IMPL;
			periph_a_in <= {WIDTH{1'b0}};
			periph_b_in <= {WIDTH{1'b0}};
		end else begin
			pin_out     <= mux_out;
			pin_oe_n    <= mux_oe_n | ~IMPL;
			pullup_on   <= ~pullup_status & IMPL;
			periph_a_in <= pin_in;
			periph_b_in <= pin_in;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	reg [31:0] rd_val;
	reg        rd_err;

	always @* begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		if (is_wr(s_axi_araddr, `PIO_OFS_OWN_STAT)) begin
			rd_val[WIDTH-1:0] = line_own_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_DRV_STAT)) begin
			rd_val[WIDTH-1:0] = drive_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_LVL_STAT)) begin
			rd_val[WIDTH-1:0] = out_level_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_PIN_STAT)) begin
			rd_val[WIDTH-1:0] = pin_level_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_IRQ_MASK)) begin
			rd_val[WIDTH-1:0] = change_irq_mask;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_IRQ_STAT)) begin
			rd_val[WIDTH-1:0] = change_irq_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_PU_STAT)) begin
			rd_val[WIDTH-1:0] = pullup_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_AB_STAT)) begin
			rd_val[WIDTH-1:0] = periph_ab_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_SWM_STAT)) begin
			rd_val[WIDTH-1:0] = sync_write_mask_status;
		end else if (is_wr(s_axi_araddr, `PIO_OFS_CLK_CTRL)) begin
			rd_val[0] = clk_on_reg;
		end else begin
			rd_err = 1'b1;
		end
		rd_isr = s_axi_arvalid & s_axi_arready & is_wr(s_axi_araddr, `PIO_OFS_IRQ_STAT);
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PIO_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_err ? `PIO_RESP_SLVERR : `PIO_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// [dv/pio_line_ctrl_monitor.sv]
// Purpose: port-level checks for the line controller
// Assumes: bound to pio_line_ctrl, one clock domain
// Notes:   pin registers lag the status words by one clock
`timescale 1ns/10ps
`include "pio_consts.vh"
module pio_line_ctrl_monitor #(
	parameter WIDTH     = 32,
	parameter IMPL_MASK = 32'hffffffff
) (
	input wire             aclk,
	input wire             aresetn,
	input wire             s_axi_awvalid,
	input wire             s_axi_awready,
	input wire             s_axi_wvalid,
	input wire             s_axi_wready,
	input wire             s_axi_bvalid,
	input wire [11:0]      s_axi_araddr,
	input wire             s_axi_arvalid,
	input wire             s_axi_arready,
	input wire             s_axi_rvalid,
	input wire [WIDTH-1:0] pin_in,
	input wire [WIDTH-1:0] pin_out,
	input wire [WIDTH-1:0] pin_oe_n,
	input wire [WIDTH-1:0] pullup_on,
	input wire [WIDTH-1:0] periph_a_out,
	input wire [WIDTH-1:0] periph_a_oe,
	input wire [WIDTH-1:0] periph_b_out,
	input wire [WIDTH-1:0] periph_b_oe,
	input wire [WIDTH-1:0] periph_a_in,
	input wire [WIDTH-1:0] periph_b_in,
	input wire             change_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_pa_in;
		$past(aresetn) |-> periph_a_in == $past(pin_in);
	endproperty
	a_pa_in: assert property (p_pa_in) else $error("peripheral A input differs from pin");
	property p_pb_in;
		$past(aresetn) |-> periph_b_in == $past(pin_in);
	endproperty
	a_pb_in: assert property (p_pb_in) else $error("peripheral B input differs from pin");
	property p_pu_rst;
		$rose(aresetn) |-> pullup_on == IMPL_MASK;
	endproperty
	a_pu_rst: assert property (p_pu_rst) else $error("pull-ups not all on after reset");
	property p_unimpl;
		(pullup_on & ~IMPL_MASK) == 0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("pull-up on an absent line");
	property p_wr_done;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write not answered in time");
	property p_rd_done;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read not answered in time");
	property p_pin_hold;
		$past(aresetn) && !$rose(s_axi_bvalid) && $stable(periph_a_out) && $stable(periph_a_oe)
			&& $stable(periph_b_out) && $stable(periph_b_oe)
			|=> $stable(pin_out) && $stable(pin_oe_n);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin drive moved without cause");
	property p_irq_clr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PIO_OFS_IRQ_STAT && $stable(pin_in)
			##1 $stable(pin_in) |=> !change_irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt kept after status read");
endmodule

bind pio_line_ctrl pio_line_ctrl_monitor #(.WIDTH(WIDTH), .IMPL_MASK(IMPL_MASK)) u_mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
	.periph_a_out(periph_a_out), .periph_a_oe(periph_a_oe), .periph_b_out(periph_b_out),
	.periph_b_oe(periph_b_oe), .periph_a_in(periph_a_in), .periph_b_in(periph_b_in),
	.change_irq(change_irq));

// [dv/pio_pin_model.sv]
// Purpose: pins and peripheral functions around the line controller
// Assumes: outside drive only on lines the controller leaves undriven
// Notes:   a floating line without pull-up toggles every clock
`timescale 1ns/10ps
module pio_pin_model #(
	parameter PA_OUT = 32'h00000300,
	parameter PA_OE  = 32'h00000f00,
	parameter PB_OUT = 32'h0000a000,
	parameter PB_OE  = 32'h00006000
) (
	input  wire        aclk,
	input  wire [31:0] pin_out,
	input  wire [31:0] pin_oe_n,
	input  wire [31:0] pullup_on,
	input  wire [31:0] ext_en,
	input  wire [31:0] ext_lvl,
	output wire [31:0] pin_in,
	output wire [31:0] periph_a_out,
	output wire [31:0] periph_a_oe,
	output wire [31:0] periph_b_out,
	output wire [31:0] periph_b_oe
);
	logic [31:0] float_reg = 32'h55555555;
	assign periph_a_out = PA_OUT;
	assign periph_a_oe = PA_OE;
	assign periph_b_out = PB_OUT;
	assign periph_b_oe = PB_OE;
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_lvl)
		| (pin_oe_n & ~ext_en & (pullup_on | float_reg));
	always @(posedge aclk) begin
		float_reg <= ~float_reg;
	end
endmodule

// [dv/pio_line_ctrl_tb_top.sv]
// Purpose: self-checking bench for the parallel line controller
// Assumes: line 31 absent, line 0 without peripheral, line 16 peripheral at reset
// Notes:   single-outstanding AXI4-Lite master
`timescale 1ns/10ps
`include "pio_consts.vh"
module pio_line_ctrl_tb_top;
	localparam IMPL = 32'h7fffffff;
	localparam MUXM = 32'hfffffffe;
	localparam OWNR = 32'hfffeffff;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] ext_en = 32'h80000000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid, change_irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata, pin_in, pin_out, pin_oe_n, pullup_on, pa_in, pb_in;
	wire  [31:0] pa_out, pa_oe, pb_out, pb_oe;
	int          error_cnt = 0;
	int          cmp_count = 0;
	logic [11:0] tab [0:20] = '{`PIO_OFS_OWN_EN, `PIO_OFS_OWN_DIS, `PIO_OFS_OWN_STAT,
		`PIO_OFS_DRV_EN, `PIO_OFS_DRV_DIS, `PIO_OFS_DRV_STAT, `PIO_OFS_LVL_SET,
		`PIO_OFS_LVL_CLR, `PIO_OFS_LVL_STAT, `PIO_OFS_B_SEL, `PIO_OFS_A_SEL, `PIO_OFS_AB_STAT,
		`PIO_OFS_PU_DIS, `PIO_OFS_PU_EN, `PIO_OFS_PU_STAT, `PIO_OFS_SWM_SET, `PIO_OFS_SWM_CLR,
		`PIO_OFS_SWM_STAT, `PIO_OFS_IRQ_EN, `PIO_OFS_IRQ_DIS, `PIO_OFS_IRQ_MASK};

	pio_line_ctrl #(.IMPL_MASK(IMPL), .MUX_MASK(MUXM), .OWN_RST(OWNR)) u_pio_line_ctrl (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
		.periph_a_out(pa_out), .periph_a_oe(pa_oe), .periph_b_out(pb_out),
		.periph_b_oe(pb_oe), .periph_a_in(pa_in), .periph_b_in(pb_in),
		.change_irq(change_irq));
	pio_pin_model u_pio_pin_model (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pullup_on(pullup_on), .ext_en(ext_en), .ext_lvl(32'h0), .pin_in(pin_in),
		.periph_a_out(pa_out), .periph_a_oe(pa_oe), .periph_b_out(pb_out),
		.periph_b_oe(pb_oe));

	// --------
	// bus tasks
	// --------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		if (n >= 40) error_cnt++;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 40);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 40) error_cnt++;
		@(posedge aclk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk($sformatf("rdata %h", a), exp, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// --------
	// scenarios
	// --------
	task automatic t_reset();
		rd_chk(`PIO_OFS_OWN_STAT, (OWNR | ~MUXM) & IMPL);
		rd_chk(`PIO_OFS_PU_STAT, 32'h0);
		rd_chk(`PIO_OFS_AB_STAT, 32'h0);
		rd_chk(`PIO_OFS_SWM_STAT, 32'h0);
		chk("pullup_on", IMPL, pullup_on);
		wr(12'h0fc, 32'h1, `PIO_RESP_SLVERR);
		rd_chk(`PIO_OFS_OWN_EN, 32'h0, `PIO_RESP_SLVERR);
	endtask
	task automatic t_setclr();
		for (int i = 0; i < 21; i += 3) begin
			wr(tab[i], 32'hffffffff);
			rd_chk(tab[i+2], IMPL);
			wr(tab[i+1], 32'h0000ffff);
			rd_chk(tab[i+2], 32'h7fff0000 | {31'h0, i == 0});
		end
		chk("pullup_on", 32'h0000ffff, pullup_on);
	endtask
	task automatic t_pins();
		wr(`PIO_OFS_OWN_EN, 32'hffffffff);
		wr(`PIO_OFS_DRV_DIS, 32'hffffffff);
		wr(`PIO_OFS_DRV_EN, 32'h0000000f);
		wr(`PIO_OFS_LVL_CLR, 32'hffffffff);
		wr(`PIO_OFS_LVL_SET, 32'h00000001);
		wr(`PIO_OFS_SWM_CLR, 32'hffffffff);
		wr(`PIO_OFS_SWM_SET, 32'h0000000a);
		wr(`PIO_OFS_LVL_STAT, 32'hffffffff);
		rd_chk(`PIO_OFS_LVL_STAT, 32'h0000000b);
		chk("pin_oe_n", 32'hfffffff0, pin_oe_n);
		chk("pin_out", 32'h0000000b, pin_out & 32'h0000000f);
		wr(`PIO_OFS_DRV_EN, 32'h0000ff00);
		wr(`PIO_OFS_A_SEL, 32'h00000f00);
		wr(`PIO_OFS_B_SEL, 32'h0000f000);
		wr(`PIO_OFS_OWN_DIS, 32'h0000ff00);
		chk("pin_oe_n", 32'hffff90f0, pin_oe_n);
		chk("pin_out", 32'h0000230b, pin_out & ~pin_oe_n);
		wr(`PIO_OFS_OWN_EN, 32'h00000f00);
		chk("pin_out", 32'h0000200b, pin_out & ~pin_oe_n);
	endtask
	task automatic t_irq();
		logic [31:0] d;
		logic [1:0]  r;
		wr(`PIO_OFS_PU_EN, 32'hffffffff);
		wr(`PIO_OFS_DRV_DIS, 32'hffffffff);
		wr(`PIO_OFS_OWN_EN, 32'hffffffff);
		wr(`PIO_OFS_IRQ_DIS, 32'hffffffff);
		ext_en <= 32'h80000100;
		rd_chk(`PIO_OFS_PIN_STAT, 32'h0);
		wr(`PIO_OFS_CLK_CTRL, 32'h1);
		rd(`PIO_OFS_IRQ_STAT, d, r);
		rd_chk(`PIO_OFS_PIN_STAT, 32'h7ffffeff);
		wr(`PIO_OFS_IRQ_EN, 32'h00000100);
		ext_en <= 32'h80000000;
		repeat (4) @(posedge aclk);
		chk("change_irq", 32'h1, {31'h0, change_irq});
		rd_chk(`PIO_OFS_IRQ_STAT, 32'h00000100);
		repeat (2) @(posedge aclk);
		chk("change_irq", 32'h0, {31'h0, change_irq});
		wr(`PIO_OFS_CLK_CTRL, 32'h0);
		ext_en <= 32'h80000100;
		repeat (4) @(posedge aclk);
		chk("change_irq", 32'h0, {31'h0, change_irq});
		rd_chk(`PIO_OFS_PIN_STAT, 32'h7fffffff);
		rd_chk(`PIO_OFS_IRQ_STAT, 32'h0);
	endtask

	// --------
	// run control
	// --------
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// no request until the edge that first samples reset released
		@(posedge aclk);
		t_reset();
		t_setclr();
		t_pins();
		t_irq();
		tally_and_finish();
	end
	// 20000 clocks, over fifty times what the scenarios need
	initial begin
		#1000000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
